// ==== dv/aps_switch_bench.sv ====
// Self-checking bench for the protection switch controller
`include "aps_map.svh"
module aps_switch_bench;
   timeunit 1ns;
   timeprecision 100ps;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc_i = 1'b0;
   logic        stb_i = 1'b0;
   logic        we_i  = 1'b0;
   logic [7:0]  adr_i = 8'h00;
   logic [3:0]  sel_i = 4'h0;
   logic [3:0]  sel_b = 4'hf;
   logic [31:0] dat_i = 32'h0;
   logic [31:0] dat_o;
   logic        ack_o, protect_mode_o, active_link_o, irq_o;
   logic [1:0]  fail_req = 2'h0;
   logic [1:0]  sd_req = 2'h0;
   logic [1:0]  fail_w, sd_w;
   int          n_errors = 0;
   int          compares = 0;
   always #12.5 clk_i = ~clk_i;
   // Short tick of 10 cycles keeps the default wait interval to 600 cycles
   aps_switch #(.TICK_CYCLES(10)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
      .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
      .ack_o(ack_o), .fail_i(fail_w), .signal_degraded_i(sd_w),
      .protect_mode_o(protect_mode_o), .active_link_o(active_link_o), .irq_o(irq_o));
   framer_model i_far (.clk_i(clk_i), .fail_req_i(fail_req), .sd_req_i(sd_req),
      .fail_o(fail_w), .sd_o(sd_w));
   task automatic end_sim;
      if (n_errors == 0 && compares > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : end_sim
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         n_errors++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
      int n;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= w;
      adr_i <= a;
      sel_i <= sel_b;
      dat_i <= d;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 20);
      if (ack_o !== 1'b1) begin
         n_errors++;
         $display("Error ack expected 1 seen %b", ack_o);
         end_sim;
      end
      q = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
   endtask : wb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
   endtask : wr
   task automatic hold(input int n);
      repeat (n) @(posedge clk_i);
   endtask : hold
   task automatic wait_link(input logic e, input int lim, input string nm);
      int n;
      n = 0;
      while (active_link_o !== e && n < lim) begin
         @(posedge clk_i);
         n++;
      end
      chk(nm, {31'h0, e}, {31'h0, active_link_o});
      if (active_link_o !== e) begin
         end_sim;
      end
   endtask : wait_link
   task automatic t_reset;
      logic [31:0] q;
      wb(1'b0, `APS_CFG_OFF, 32'h0, q);
      chk("cfg", 32'h28, q);
      chk("prot", 32'h0, {31'h0, protect_mode_o});
      chk("link", 32'h0, {31'h0, active_link_o});
      wb(1'b0, `APS_WTR_OFF, 32'h0, q);
      chk("wtr", 32'h3c, q);
      wb(1'b0, 8'h20, 32'h0, q);
      chk("unmapped", 32'h0, q);
      sel_b = 4'he;
      wr(`APS_CFG_OFF, 32'h07);
      sel_b = 4'hf;
      wb(1'b0, `APS_CFG_OFF, 32'h0, q);
      chk("cfg_sel", 32'h28, q);
   endtask : t_reset
   task automatic t_noprot;
      fail_req <= 2'h1;
      hold(20);
      chk("link", 32'h0, {31'h0, active_link_o});
      fail_req <= 2'h0;
      hold(10);
      wr(`APS_IRQ_STAT_OFF, 32'h7);
   endtask : t_noprot
   task automatic t_nonrev;
      logic [31:0] q;
      wr(`APS_CFG_OFF, 32'h29);
      hold(2);
      chk("prot", 32'h0, {31'h0, protect_mode_o});
      wr(`APS_COMMIT_OFF, 32'h1);
      hold(2);
      chk("prot", 32'h1, {31'h0, protect_mode_o});
      fail_req <= 2'h1;
      wait_link(1'b1, 20, "link");
      wb(1'b0, `APS_IRQ_STAT_OFF, 32'h0, q);
      chk("irq_stat", 32'h1, {31'h0, q[0]});
      wr(`APS_IRQ_MASK_OFF, 32'h0);
      hold(1);
      chk("irq_masked", 32'h0, {31'h0, irq_o});
      wr(`APS_IRQ_MASK_OFF, 32'h7);
      hold(1);
      chk("irq_mask", 32'h1, {31'h0, irq_o});
      fail_req <= 2'h0;
      hold(20);
      chk("link", 32'h1, {31'h0, active_link_o});
      sd_req <= 2'h2;
      hold(20);
      chk("link", 32'h1, {31'h0, active_link_o});
      sd_req <= 2'h0;
      fail_req <= 2'h2;
      wait_link(1'b0, 20, "link");
      fail_req <= 2'h0;
      hold(10);
      wr(`APS_IRQ_STAT_OFF, 32'h7);
      wb(1'b0, `APS_IRQ_STAT_OFF, 32'h0, q);
      chk("irq_stat", 32'h0, q);
      chk("irq", 32'h0, {31'h0, irq_o});
   endtask : t_nonrev
   task automatic t_degrade;
      wr(`APS_CFG_OFF, 32'h2b);
      wr(`APS_COMMIT_OFF, 32'h1);
      sd_req <= 2'h1;
      wait_link(1'b1, 20, "link");
      sd_req <= 2'h0;
   endtask : t_degrade
   task automatic t_revert;
      logic [31:0] q;
      wr(`APS_WTR_OFF, 32'h3);
      wr(`APS_CFG_OFF, 32'h2d);
      wr(`APS_COMMIT_OFF, 32'h1);
      wait_link(1'b0, 5, "link");
      // Wait loaded by the degrade switch still runs
      hold(620);
      fail_req <= 2'h1;
      wait_link(1'b1, 20, "link");
      fail_req <= 2'h0;
      hold(8);
      chk("link", 32'h1, {31'h0, active_link_o});
      wait_link(1'b0, 80, "link");
      wr(`APS_WTR_OFF, 32'h2d1);
      wb(1'b0, `APS_WTR_OFF, 32'h0, q);
      chk("wtr", 32'h3, q);
   endtask : t_revert
   task automatic t_manual;
      logic [31:0] q;
      wr(`APS_CFG_OFF, 32'h31);
      wr(`APS_COMMIT_OFF, 32'h1);
      wait_link(1'b1, 5, "link");
      wb(1'b0, `APS_CFG_OFF, 32'h0, q);
      chk("cfg_excl", 32'h11, q);
      wr(`APS_STAT_OFF, 32'h0);
      wb(1'b0, `APS_STAT_OFF, 32'h0, q);
      chk("status", 32'h3, {30'h0, q[1:0]});
      wr(`APS_CFG_OFF, 32'h28);
      wr(`APS_COMMIT_OFF, 32'h1);
      hold(2);
      chk("prot", 32'h0, {31'h0, protect_mode_o});
   endtask : t_manual
   initial begin
      hold(20);
      rst_i <= 1'b0;
      t_reset;
      t_noprot;
      t_nonrev;
      t_degrade;
      t_revert;
      t_manual;
      end_sim;
   end
endmodule : aps_switch_bench

// ==== dv/framer_model.sv ====
// Framer alarm model for the two network links
module framer_model (
   // Clock
   input  wire logic       clk_i,
   // Alarm requests from the bench
   input  wire logic [1:0] fail_req_i,
   input  wire logic [1:0] sd_req_i,
   // Alarm levels toward the switch
   output logic      [1:0] fail_o,
   output logic      [1:0] sd_o
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      fail_o = 2'h0;
      sd_o   = 2'h0;
   end
   // Levels leave a register, never glitching between edges
   always @(posedge clk_i) begin
      fail_o <= fail_req_i;
      sd_o   <= sd_req_i;
   end
endmodule : framer_model

// ==== logic/aps_map.svh ====
// Register offsets, field positions, reset values and timing for the protection switch
`ifndef APS_MAP_SVH
`define APS_MAP_SVH
`define APS_CFG_OFF        8'h00
`define APS_WTR_OFF        8'h04
`define APS_COMMIT_OFF     8'h08
`define APS_STAT_OFF       8'h0c
`define APS_IRQ_STAT_OFF   8'h10
`define APS_IRQ_MASK_OFF   8'h14
`define APS_CFG_PROT_BIT   0
`define APS_CFG_SDEG_BIT   1
`define APS_CFG_REV_BIT    2
`define APS_CFG_WSEL_LSB   3
`define APS_CFG_PSEL_BIT   5
`define APS_WSEL_AUTO      2'h0
`define APS_WSEL_LINK1     2'h1
`define APS_WSEL_LINK2     2'h2
`define APS_WTR_DEFAULT    10'h03c
`define APS_WTR_MIN        10'h001
`define APS_WTR_MAX        10'h2d0
`define APS_TICK_SECONDS   1
`define APS_CLK_HZ         40000000
`define APS_TICK_CYCLES    (`APS_TICK_SECONDS * `APS_CLK_HZ)
`define APS_IRQ_SWITCH     0
`define APS_IRQ_FAIL1      1
`define APS_IRQ_FAIL2      2
`endif

// ==== logic/aps_pkg.sv ====
// Types for the protection switch controller
package aps_pkg;
   typedef struct packed {
      logic       prot_en;
      logic       sdeg_en;
      logic       revert;
      logic [1:0] wsel;
      logic       psel;
      logic [9:0] wait_to_restore_time;
   } aps_cfg_t;
endpackage : aps_pkg

// ==== logic/aps_switch.sv ====
// 1+1 link protection switch controller with Wishbone registers
// Notes on behaviour
// - protection off: both links run independently
// - protection on: one link backs up working
// - protection defaults off; on gives automatic switching
// - degrade switches only when switch_on_degrade set
// - non-revertive: stay, switch only on failure
// - revertive: return to configured working link
// - working select auto/link1/link2, default link1
// - wait interval applies only in revertive mode
// - read-only status shows active working link
//
// The implementer's own choices: the register offsets and register access over Wishbone.
`include "aps_map.svh"
module aps_switch #(
   parameter int unsigned TICK_CYCLES = `APS_TICK_CYCLES
) (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Wishbone slave
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   // Framer alarms, asynchronous
   input  wire logic [1:0]  fail_i,
   input  wire logic [1:0]  signal_degraded_i,
   // Traffic control
   output logic             protect_mode_o,
   output logic             active_link_o,
   output logic             irq_o
);
   typedef struct packed {
      aps_pkg::aps_cfg_t pend;
      aps_pkg::aps_cfg_t cfg;
      logic              active;
      logic [31:0]       tick_cnt;
      logic [9:0]        wtr_cnt;
      logic [2:0]        sync_f;
      logic [2:0]        sync_f2;
      logic [2:0]        sync_d;
      logic [2:0]        sync_d2;
      logic [1:0]        fail_s;
      logic [1:0]        deg_s;
      logic [2:0]        istat;
      logic [2:0]        imask;
      logic              ack;
      logic [31:0]       rdat;
   } state_t;

   state_t q, d;
   aps_pkg::aps_cfg_t dflt;
   logic        wr;
   logic        rd_req;
   logic [1:0]  bad;
   logic        home;
   logic        hold;
   logic        tick;
   logic        sw_now;
   logic [2:0]  ev;
   logic        commit;

   always_comb begin
      dflt         = '0;
      dflt.wsel    = `APS_WSEL_LINK1;
      dflt.psel    = 1'b1;
      dflt.wait_to_restore_time     = `APS_WTR_DEFAULT;
   end

   assign wr     = cyc_i && stb_i && we_i && !q.ack;
   assign rd_req = cyc_i && stb_i && !q.ack;
   // Home link: manual selection, auto keeps link 1
   assign home   = (q.cfg.wsel == `APS_WSEL_LINK2) ? 1'b1 : 1'b0;
   assign tick   = (q.tick_cnt == TICK_CYCLES - 1);
   assign hold   = q.cfg.revert && (q.wtr_cnt != 10'h000);
   // Commit strobe, shared by the checks below
   assign commit = wr && sel_i[0] && (adr_i == `APS_COMMIT_OFF) && dat_i[0];

   always_comb begin
      d   = q;
      bad = '0;
      sw_now = 1'b0;
      ev  = '0;
      // Three-stage sync, change accepted when stages 2 and 3 agree
      d.sync_f  = {q.sync_f[1:0], 1'b0};
      d.sync_f2 = {q.sync_f2[1:0], 1'b0};
      d.sync_d  = {q.sync_d[1:0], 1'b0};
      d.sync_d2 = {q.sync_d2[1:0], 1'b0};
      d.sync_f[0]  = fail_i[0];
      d.sync_f2[0] = fail_i[1];
      d.sync_d[0]  = signal_degraded_i[0];
      d.sync_d2[0] = signal_degraded_i[1];
      if (q.sync_f[2] == q.sync_f[1])   d.fail_s[0] = q.sync_f[2];
      if (q.sync_f2[2] == q.sync_f2[1]) d.fail_s[1] = q.sync_f2[2];
      if (q.sync_d[2] == q.sync_d[1])   d.deg_s[0] = q.sync_d[2];
      if (q.sync_d2[2] == q.sync_d2[1]) d.deg_s[1] = q.sync_d2[2];
      bad = q.fail_s | (q.cfg.sdeg_en ? q.deg_s : 2'b00);

      d.tick_cnt = tick ? 32'h0 : q.tick_cnt + 32'h1;
      if (q.wtr_cnt != 10'h000 && tick) d.wtr_cnt = q.wtr_cnt - 10'h001;

      if (q.cfg.prot_en) begin
         // alarms masked during the wait interval
         if (!hold) begin
            // switch only when the active link fails
            if (bad[q.active] && !bad[!q.active]) sw_now = 1'b1;
            // revert to home once it is healthy
            else if (q.cfg.revert && q.active != home && !bad[home]) sw_now = 1'b1;
         end
      end
      if (sw_now) begin
         d.active = !q.active;
         // restart the wait on each activation
         d.wtr_cnt = q.cfg.wait_to_restore_time;
         d.tick_cnt = 32'h0;
      end
      ev[`APS_IRQ_SWITCH] = sw_now;
      ev[`APS_IRQ_FAIL1]  = d.fail_s[0] && !q.fail_s[0];
      ev[`APS_IRQ_FAIL2]  = d.fail_s[1] && !q.fail_s[1];

      // Bus slave, one ack per request, registered one cycle after it
      d.ack = rd_req;
      if (wr && sel_i[0]) begin
         unique case (adr_i)
            `APS_CFG_OFF: begin
               d.pend.prot_en = dat_i[`APS_CFG_PROT_BIT];
               d.pend.sdeg_en = dat_i[`APS_CFG_SDEG_BIT];
               d.pend.revert  = dat_i[`APS_CFG_REV_BIT];
               d.pend.wsel = dat_i[`APS_CFG_WSEL_LSB +: 2];
               if (dat_i[`APS_CFG_WSEL_LSB +: 2] == `APS_WSEL_LINK1)
                  d.pend.psel = 1'b1;
               else if (dat_i[`APS_CFG_WSEL_LSB +: 2] == `APS_WSEL_LINK2)
                  d.pend.psel = 1'b0;
               else begin
                  d.pend.psel = dat_i[`APS_CFG_PSEL_BIT];
                  d.pend.wsel = dat_i[`APS_CFG_PSEL_BIT] ? `APS_WSEL_LINK1
                                                          : `APS_WSEL_LINK2;
                  if (dat_i[`APS_CFG_WSEL_LSB +: 2] == `APS_WSEL_AUTO)
                     d.pend.wsel = `APS_WSEL_AUTO;
               end
            end
            `APS_WTR_OFF: begin
               if (sel_i[1] && {dat_i[9:8], dat_i[7:0]} >= `APS_WTR_MIN
                   && dat_i[9:0] <= `APS_WTR_MAX)
                  d.pend.wait_to_restore_time = dat_i[9:0];
            end
            `APS_COMMIT_OFF: begin
               if (dat_i[0]) begin
                  d.cfg = q.pend;
                  if (q.pend.wsel == `APS_WSEL_LINK1) d.active = 1'b0;
                  else if (q.pend.wsel == `APS_WSEL_LINK2) d.active = 1'b1;
                  if (!q.pend.prot_en) d.wtr_cnt = 10'h000;
               end
            end
            `APS_IRQ_MASK_OFF: d.imask = dat_i[2:0];
            default: ;
         endcase
      end
      // Set wins over write-one-to-clear
      if (wr && sel_i[0] && adr_i == `APS_IRQ_STAT_OFF) d.istat = q.istat & ~dat_i[2:0];
      d.istat = d.istat | ev;

      d.rdat = 32'h0;
      unique case (adr_i)
         `APS_CFG_OFF:      d.rdat = {26'h0, q.pend.psel, q.pend.wsel, q.pend.revert,
                                      q.pend.sdeg_en, q.pend.prot_en};
         `APS_WTR_OFF:      d.rdat = {22'h0, q.pend.wait_to_restore_time};
         `APS_STAT_OFF:     d.rdat = {20'h0, q.wtr_cnt, q.active, q.cfg.prot_en};
         `APS_IRQ_STAT_OFF: d.rdat = {29'h0, q.istat};
         `APS_IRQ_MASK_OFF: d.rdat = {29'h0, q.imask};
         default:           d.rdat = 32'h0;
      endcase
      if (!rd_req) d.rdat = q.rdat;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q      <= '0;
         q.pend <= dflt;
         q.cfg  <= dflt;
      end else begin
         q <= d;
      end
   end

   assign dat_o = q.rdat;
   assign ack_o = q.ack;
   // protect mode: one link carries traffic
   assign protect_mode_o = q.cfg.prot_en;
   assign active_link_o  = q.active;
   assign irq_o          = |(q.istat & q.imask);

   a_switch_on_fail: assert property (@(posedge clk_i) disable iff (rst_i)
      q.cfg.prot_en && !hold && bad[q.active] && !bad[!q.active] && !wr
      |=> active_link_o != $past(active_link_o))
      else $error("active link did not switch on failure");
   a_no_prot_stay: assert property (@(posedge clk_i) disable iff (rst_i)
      !q.cfg.prot_en && !wr |=> $stable(active_link_o))
      else $error("link changed with protection off");
   a_degrade_gate: assert property (@(posedge clk_i) disable iff (rst_i)
      !q.cfg.sdeg_en && !q.fail_s[q.active] && !q.cfg.revert && !wr
      |=> $stable(active_link_o))
      else $error("degrade switched while disabled");
   a_wait_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      hold && !wr |=> $stable(active_link_o))
      else $error("switch during wait interval");
   a_wait_load: assert property (@(posedge clk_i) disable iff (rst_i)
      sw_now && !commit |=> q.wtr_cnt == $past(q.cfg.wait_to_restore_time))
      else $error("wait counter not restarted");
   a_revert_home: assert property (@(posedge clk_i) disable iff (rst_i)
      q.cfg.prot_en && q.cfg.revert && !hold && active_link_o != home && !bad[home] && !wr
      |=> active_link_o == home)
      else $error("no revert to home link");
   a_excl_select: assert property (@(posedge clk_i) disable iff (rst_i)
      q.pend.wsel == `APS_WSEL_LINK1 |-> q.pend.psel)
      else $error("working and protection overlap");
   a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
      ack_o |=> !ack_o)
      else $error("ack longer than one cycle");

   a_reset_prot_off: assert property (@(posedge clk_i)
      rst_i |=> !protect_mode_o && !active_link_o && !ack_o)
      else $error("protection or link not cleared by reset");

   a_reset_defaults: assert property (@(posedge clk_i)
      rst_i |=> q.cfg.wsel == `APS_WSEL_LINK1 && q.cfg.psel
                && q.cfg.wait_to_restore_time == `APS_WTR_DEFAULT && !q.cfg.revert && !q.cfg.sdeg_en)
      else $error("configuration defaults not restored by reset");

   a_commit_apply: assert property (@(posedge clk_i) disable iff (rst_i)
      commit |=> q.cfg == $past(q.pend))
      else $error("pending settings not applied on commit");

   a_cfg_held: assert property (@(posedge clk_i) disable iff (rst_i)
      !commit |=> $stable(q.cfg))
      else $error("settings changed without commit");

   a_manual_link1: assert property (@(posedge clk_i) disable iff (rst_i)
      commit && q.pend.wsel == `APS_WSEL_LINK1 |=> !active_link_o)
      else $error("manual link 1 selection not applied");

   a_manual_link2: assert property (@(posedge clk_i) disable iff (rst_i)
      commit && q.pend.wsel == `APS_WSEL_LINK2 |=> active_link_o)
      else $error("manual link 2 selection not applied");

   a_excl_link2: assert property (@(posedge clk_i) disable iff (rst_i)
      q.pend.wsel == `APS_WSEL_LINK2 |-> !q.pend.psel)
      else $error("link 2 both working and protection");

   a_wtr_range: assert property (@(posedge clk_i) disable iff (rst_i)
      q.pend.wait_to_restore_time >= `APS_WTR_MIN && q.pend.wait_to_restore_time <= `APS_WTR_MAX)
      else $error("wait interval outside its range");

   a_wait_count: assert property (@(posedge clk_i) disable iff (rst_i)
      tick && q.wtr_cnt != 10'h000 && !sw_now && !commit
      |=> q.wtr_cnt == $past(q.wtr_cnt) - 10'h001)
      else $error("wait counter missed a tick");

   a_tick_range: assert property (@(posedge clk_i) disable iff (rst_i)
      q.tick_cnt <= TICK_CYCLES - 1)
      else $error("tick counter overran its period");

   a_both_bad_stay: assert property (@(posedge clk_i) disable iff (rst_i)
      bad == 2'b11 && !wr |=> $stable(active_link_o))
      else $error("switched with both links bad");

   a_nonrev_stay: assert property (@(posedge clk_i) disable iff (rst_i)
      !q.cfg.revert && !bad[q.active] && !wr |=> $stable(active_link_o))
      else $error("non-revertive switch from a healthy link");

   a_degrade_switch: assert property (@(posedge clk_i) disable iff (rst_i)
      q.cfg.prot_en && q.cfg.sdeg_en && !hold && q.deg_s[q.active]
      && !bad[!q.active] && !wr |=> active_link_o != $past(active_link_o))
      else $error("no switch on degrade");

   a_noprot_wait_clr: assert property (@(posedge clk_i) disable iff (rst_i)
      commit && !q.pend.prot_en |=> q.wtr_cnt == 10'h000)
      else $error("wait counter kept with protection off");

   a_ack_answer: assert property (@(posedge clk_i) disable iff (rst_i)
      rd_req |=> ack_o)
      else $error("request not acknowledged");

   a_switch_flag: assert property (@(posedge clk_i) disable iff (rst_i)
      sw_now |=> q.istat[`APS_IRQ_SWITCH])
      else $error("switch event not recorded");

   a_fail_flag: assert property (@(posedge clk_i) disable iff (rst_i)
      !q.fail_s[1] ##1 q.fail_s[1] |-> q.istat[`APS_IRQ_FAIL2])
      else $error("link 2 failure not recorded");
endmodule : aps_switch
